// ===== accel_buf_pkg.sv
// constants and types for the acceleration frame buffer
package accel_buf_pkg;

    localparam int         AXIS_W          = 16;
    localparam int         DEPTH           = 32;
    localparam int         PTR_W           = 5;
    localparam int         CNT_W           = 6;
    localparam int         IDX_W           = 6;

    // register indexes, byte address is four times the index
    localparam logic [5:0] IDX_X_LO        = 6'h02;
    localparam logic [5:0] IDX_X_HI        = 6'h03;
    localparam logic [5:0] IDX_Y_LO        = 6'h04;
    localparam logic [5:0] IDX_Y_HI        = 6'h05;
    localparam logic [5:0] IDX_Z_LO        = 6'h06;
    localparam logic [5:0] IDX_Z_HI        = 6'h07;
    localparam logic [5:0] IDX_IRQ_STATUS  = 6'h0A;
    localparam logic [5:0] IDX_FRAME_COUNT = 6'h0E;
    localparam logic [5:0] IDX_RO_LAST     = 6'h0E;
    localparam logic [5:0] IDX_SOFT_RESET  = 6'h14;
    localparam logic [5:0] IDX_IRQ_ENABLE  = 6'h17;
    localparam logic [5:0] IDX_IRQ_MAP     = 6'h1A;
    localparam logic [5:0] IDX_IRQ_CTRL    = 6'h21;
    localparam logic [5:0] IDX_WM_LEVEL    = 6'h30;
    localparam logic [5:0] IDX_MODE_AXIS   = 6'h3E;
    localparam logic [5:0] IDX_READOUT     = 6'h3F;

    // field positions
    localparam int         MODE_HI         = 7;
    localparam int         MODE_LO         = 6;
    localparam int         AXIS_HI         = 1;
    localparam int         AXIS_LO         = 0;
    localparam int         WM_LEVEL_W      = 6;
    localparam int         OVERRUN_BIT     = 7;
    localparam int         WM_BIT          = 6;
    localparam int         FULL_BIT        = 5;
    localparam int         WM_PIN_A_BIT    = 1;
    localparam int         FULL_PIN_A_BIT  = 2;
    localparam int         FULL_PIN_B_BIT  = 5;
    localparam int         WM_PIN_B_BIT    = 6;

    // mode and axis encodings
    localparam logic [1:0] MODE_BYPASS     = 2'h0;
    localparam logic [1:0] MODE_KEEP_FIRST = 2'h1;
    localparam logic [1:0] MODE_STREAM     = 2'h2;
    localparam logic [1:0] AXIS_ALL        = 2'h0;
    localparam logic [1:0] AXIS_X          = 2'h1;
    localparam logic [1:0] AXIS_Y          = 2'h2;
    localparam logic [1:0] AXIS_Z          = 2'h3;

    localparam logic [5:0] CAP_KEEP_FIRST  = 6'h20;
    localparam logic [5:0] CAP_STREAM      = 6'h1F;
    localparam logic [5:0] CAP_BYPASS      = 6'h01;

    localparam logic [2:0] BYTES_ALL       = 3'h6;
    localparam logic [2:0] BYTES_ONE       = 3'h2;

    // reset values
    localparam logic [1:0] MODE_RESET      = 2'h0;
    localparam logic [1:0] AXIS_RESET      = 2'h0;
    localparam logic [5:0] WM_LEVEL_RESET  = 6'h00;
    localparam logic [7:0] SOFT_RESET_KEY  = 8'hB6;

    // partial frame discard gap
    localparam int         CLK_PERIOD_PS   = 5000;
    localparam int         PARTIAL_GAP_PS  = 1500000;
    localparam int         PARTIAL_GAP_CYC = (PARTIAL_GAP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int         GAP_W           = 9;

    typedef struct packed {
        logic [AXIS_W-1:0] x;
        logic [AXIS_W-1:0] y;
        logic [AXIS_W-1:0] z;
    } accel_frame_t;

endpackage

// ===== accel_sample_fifo.sv
// acceleration frame buffer with AHB-Lite register slave
`timescale 1ns/1ps

// Behaviour
// - keep-first mode stops at 32 frames
// - frame holds x, y, z from one sample
// - stream mode depth 31, drops oldest
// - bypass mode is stream of depth one
// - mode 00 bypass, 01 keep-first, 10 stream
// - config writes empty buffer and clear flags
// - mode field reads back current mode
// - buffer data equals result register data
// - readout port delivers buffer bytes
// - axis field 00 all, 01 x, 10 y, 11 z
// - frame capacity independent of axis selection
// - partial frame dropped after idle gap
// - reads beyond fill level return zero
// - frame count shows frames held
// - overrun set when frame arrives while full
// - overrun survives drain, cleared by config
// - watermark when count reaches programmed level
// - watermark enabled, mapped, readable in status
// - full at 32, 31 or 1 frames
// - writes to low read-only range ignored
// - sequence-launch bits read as zero
module accel_sample_fifo
    import accel_buf_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic         hsel,
    input  wire logic [31:0]  haddr,
    input  wire logic [1:0]   htrans,
    input  wire logic         hwrite,
    input  wire logic [2:0]   hsize,
    input  wire logic [31:0]  hwdata,
    input  wire logic         hready,
    output logic              hreadyout,
    output logic [31:0]       hrdata,
    output logic              hresp,
    input  wire logic         sample_valid,
    input  wire accel_frame_t sample,
    output logic              irq_pin_a,
    output logic              irq_pin_b
);

    accel_frame_t             mem [DEPTH];
    accel_frame_t             latest;
    logic [PTR_W-1:0]         wr_ptr;
    logic [PTR_W-1:0]         rd_ptr;
    logic [CNT_W-1:0]         count;
    logic [2:0]               byte_ptr;
    logic [GAP_W-1:0]         gap_cnt;
    logic                     overrun;
    logic [1:0]               mode;
    logic [1:0]               axis_sel;
    logic [WM_LEVEL_W-1:0]    wm_level;
    logic                     wm_en;
    logic                     full_en;
    logic                     wm_to_pin_a;
    logic                     wm_to_pin_b;
    logic                     full_to_pin_a;
    logic                     full_to_pin_b;
    logic                     wr_pend;
    logic [IDX_W-1:0]         wr_idx;

    logic                     addr_ok;
    logic [IDX_W-1:0]         a_idx;
    logic                     a_hi_zero;
    logic                     rd_access;
    logic                     rd_buf;
    logic                     cfg_write;
    logic                     soft_reset;
    logic                     clear;
    logic [CNT_W-1:0]         cap;
    logic                     is_full;
    logic                     wm_hit;
    logic                     wm_status;
    logic                     full_status;
    logic [2:0]               last_byte;
    logic                     gap_expire;
    logic                     pop;
    logic                     overwrite;
    logic                     push_ok;
    logic                     mem_we;
    logic [PTR_W-1:0]         mem_waddr;
    logic [7:0]               buf_byte;
    logic [7:0]               next_rdata;
    logic [AXIS_W-1:0]        sel_word;
    logic [CNT_W-1:0]         next_count;

    // bus decode
    assign addr_ok    = hsel && htrans[1] && hready;
    assign a_idx      = haddr[7:2];
    assign a_hi_zero  = (haddr[31:8] == 24'h000000);
    assign rd_access  = addr_ok && !hwrite && a_hi_zero && (a_idx == IDX_READOUT);
    assign rd_buf     = rd_access && (count != 6'h00);
    assign cfg_write  = wr_pend && ((wr_idx == IDX_MODE_AXIS) || (wr_idx == IDX_WM_LEVEL));
    assign soft_reset = wr_pend && (wr_idx == IDX_SOFT_RESET) && (hwdata[7:0] == SOFT_RESET_KEY);
    assign clear      = cfg_write || soft_reset;

    // capacity per mode, reserved code behaves as bypass
    always_comb begin
        case (mode)
            MODE_KEEP_FIRST: cap = CAP_KEEP_FIRST;
            MODE_STREAM:     cap = CAP_STREAM;
            default:         cap = CAP_BYPASS;
        endcase
    end

    assign is_full     = (count >= cap);
    assign wm_hit      = (wm_level != 6'h00) && (count >= wm_level);
    assign wm_status   = wm_en && wm_hit;
    assign full_status = full_en && is_full;
    assign last_byte   = (axis_sel == AXIS_ALL) ? BYTES_ALL - 3'h1 : BYTES_ONE - 3'h1;
    assign gap_expire  = !rd_access && (byte_ptr != 3'h0) &&
                         (gap_cnt == GAP_W'(PARTIAL_GAP_CYC - 1));
    assign pop         = (rd_buf && (byte_ptr == last_byte)) || gap_expire;
    assign overwrite   = sample_valid && is_full && !pop && (mode != MODE_KEEP_FIRST);
    assign push_ok     = sample_valid && (!is_full || pop);
    assign mem_we      = sample_valid && (clear || push_ok || overwrite);
    assign mem_waddr   = clear ? '0 : wr_ptr;

    always_comb begin
        next_count = count;
        if (push_ok && !pop) begin
            next_count = count + 6'h01;
        end else if (pop && !push_ok) begin
            next_count = count - 6'h01;
        end
    end

    // frame storage, whole frame kept whatever the axis choice
    always_ff @(posedge clk) begin
        if (mem_we) begin
            mem[mem_waddr] <= sample;
        end
    end

    // result registers hold the same values the buffer stores
    always_ff @(posedge clk) begin
        if (!nrst) begin
            latest <= '0;
        end else if (sample_valid) begin
            latest <= sample;
        end
    end

    // pointers and fill level
    always_ff @(posedge clk) begin
        if (!nrst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else if (clear) begin
            rd_ptr <= '0;
            wr_ptr <= sample_valid ? PTR_W'(1) : '0;
            count  <= sample_valid ? 6'h01 : 6'h00;
        end else begin
            if (push_ok || overwrite) begin
                wr_ptr <= wr_ptr + PTR_W'(1);
            end
            if (pop || overwrite) begin
                rd_ptr <= rd_ptr + PTR_W'(1);
            end
            count <= next_count;
        end
    end

    // overrun flag, a frame meeting a clear lands in the emptied buffer
    always_ff @(posedge clk) begin
        if (!nrst) begin
            overrun <= 1'b0;
        end else if (sample_valid && is_full && !pop && !clear) begin
            overrun <= 1'b1;
        end else if (clear) begin
            overrun <= 1'b0;
        end
    end

    // byte position within the frame being read
    always_ff @(posedge clk) begin
        if (!nrst) begin
            byte_ptr <= 3'h0;
        end else if (clear || gap_expire || overwrite) begin
            byte_ptr <= 3'h0;
        end else if (rd_buf) begin
            byte_ptr <= (byte_ptr == last_byte) ? 3'h0 : byte_ptr + 3'h1;
        end
    end

    // idle time since the last readout access
    always_ff @(posedge clk) begin
        if (!nrst) begin
            gap_cnt <= '0;
        end else if (clear || rd_access || byte_ptr == 3'h0 || gap_expire) begin
            gap_cnt <= '0;
        end else begin
            gap_cnt <= gap_cnt + GAP_W'(1);
        end
    end

    // configuration registers
    always_ff @(posedge clk) begin
        if (!nrst || soft_reset) begin
            mode          <= MODE_RESET;
            axis_sel      <= AXIS_RESET;
            wm_level      <= WM_LEVEL_RESET;
            wm_en         <= 1'b0;
            full_en       <= 1'b0;
            wm_to_pin_a   <= 1'b0;
            wm_to_pin_b   <= 1'b0;
            full_to_pin_a <= 1'b0;
            full_to_pin_b <= 1'b0;
        end else if (wr_pend && wr_idx > IDX_RO_LAST) begin
            if (wr_idx == IDX_MODE_AXIS) begin
                mode     <= hwdata[MODE_HI:MODE_LO];
                axis_sel <= hwdata[AXIS_HI:AXIS_LO];
            end else if (wr_idx == IDX_WM_LEVEL) begin
                wm_level <= hwdata[WM_LEVEL_W-1:0];
            end else if (wr_idx == IDX_IRQ_ENABLE) begin
                wm_en   <= hwdata[WM_BIT];
                full_en <= hwdata[FULL_BIT];
            end else if (wr_idx == IDX_IRQ_MAP) begin
                wm_to_pin_a   <= hwdata[WM_PIN_A_BIT];
                wm_to_pin_b   <= hwdata[WM_PIN_B_BIT];
                full_to_pin_a <= hwdata[FULL_PIN_A_BIT];
                full_to_pin_b <= hwdata[FULL_PIN_B_BIT];
            end
        end
    end

    // readout byte order x lo, x hi, y lo, y hi, z lo, z hi
    always_comb begin
        sel_word = mem[rd_ptr].x;
        if (axis_sel == AXIS_ALL) begin
            if (byte_ptr[2]) begin
                sel_word = mem[rd_ptr].z;
            end else if (byte_ptr[1]) begin
                sel_word = mem[rd_ptr].y;
            end
        end else if (axis_sel == AXIS_Y) begin
            sel_word = mem[rd_ptr].y;
        end else if (axis_sel == AXIS_Z) begin
            sel_word = mem[rd_ptr].z;
        end
        if (axis_sel == AXIS_ALL) begin
            buf_byte = (byte_ptr == 3'h1 || byte_ptr == 3'h3 || byte_ptr == 3'h5) ?
                       sel_word[15:8] : sel_word[7:0];
        end else begin
            buf_byte = byte_ptr[0] ? sel_word[15:8] : sel_word[7:0];
        end
        if (count == 6'h00) begin
            buf_byte = 8'h00;
        end
    end

    // register read mux
    always_comb begin
        next_rdata = 8'h00;
        if (!a_hi_zero) begin
            next_rdata = 8'h00;
        end else if (a_idx == IDX_X_LO) begin
            next_rdata = latest.x[7:0];
        end else if (a_idx == IDX_X_HI) begin
            next_rdata = latest.x[15:8];
        end else if (a_idx == IDX_Y_LO) begin
            next_rdata = latest.y[7:0];
        end else if (a_idx == IDX_Y_HI) begin
            next_rdata = latest.y[15:8];
        end else if (a_idx == IDX_Z_LO) begin
            next_rdata = latest.z[7:0];
        end else if (a_idx == IDX_Z_HI) begin
            next_rdata = latest.z[15:8];
        end else if (a_idx == IDX_IRQ_STATUS) begin
            next_rdata[WM_BIT]   = wm_status;
            next_rdata[FULL_BIT] = full_status;
        end else if (a_idx == IDX_FRAME_COUNT) begin
            next_rdata[OVERRUN_BIT] = overrun;
            next_rdata[6:0]         = {1'b0, count};
        end else if (a_idx == IDX_IRQ_ENABLE) begin
            next_rdata[WM_BIT]   = wm_en;
            next_rdata[FULL_BIT] = full_en;
        end else if (a_idx == IDX_IRQ_MAP) begin
            next_rdata[WM_PIN_A_BIT]   = wm_to_pin_a;
            next_rdata[WM_PIN_B_BIT]   = wm_to_pin_b;
            next_rdata[FULL_PIN_A_BIT] = full_to_pin_a;
            next_rdata[FULL_PIN_B_BIT] = full_to_pin_b;
        end else if (a_idx == IDX_SOFT_RESET || a_idx == IDX_IRQ_CTRL) begin
            next_rdata = 8'h00;
        end else if (a_idx == IDX_WM_LEVEL) begin
            next_rdata[WM_LEVEL_W-1:0] = wm_level;
        end else if (a_idx == IDX_MODE_AXIS) begin
            next_rdata[MODE_HI:MODE_LO] = mode;
            next_rdata[AXIS_HI:AXIS_LO] = axis_sel;
        end else if (a_idx == IDX_READOUT) begin
            next_rdata = buf_byte;
        end
    end

    // bus slave: zero wait, always okay
    always_ff @(posedge clk) begin
        if (!nrst) begin
            wr_pend   <= 1'b0;
            wr_idx    <= '0;
            hrdata    <= 32'h00000000;
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            wr_pend   <= addr_ok && hwrite && a_hi_zero;
            wr_idx    <= a_idx;
            if (addr_ok && !hwrite) begin
                hrdata <= {24'h000000, next_rdata};
            end
        end
    end

    // interrupt pins
    always_ff @(posedge clk) begin
        if (!nrst) begin
            irq_pin_a <= 1'b0;
            irq_pin_b <= 1'b0;
        end else begin
            irq_pin_a <= (wm_status && wm_to_pin_a) || (full_status && full_to_pin_a);
            irq_pin_b <= (wm_status && wm_to_pin_b) || (full_status && full_to_pin_b);
        end
    end

endmodule

// ===== accel_sample_fifo_sva.sv
// port-level assertion checker for the acceleration frame buffer
`timescale 1ns/1ps
module accel_sample_fifo_sva
    import accel_buf_pkg::*;
(
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic        hresp,
    input wire logic        sample_valid,
    input wire logic        irq_pin_a,
    input wire logic        irq_pin_b
);
    logic       take;
    logic [5:0] idx;
    logic       low_addr;

    assign take     = hsel && htrans[1] && hready;
    assign idx      = haddr[7:2];
    assign low_addr = (haddr[31:8] == 24'h0);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_resp_okay: assert property (!hresp) else $error("response is not OKAY");
    a_ready_high: assert property ($past(nrst) |-> hreadyout) else $error("hreadyout low after reset");
    a_pins_reset: assert property (!$past(nrst) |-> !irq_pin_a && !irq_pin_b) else $error("irq pin high out of reset");
    a_upper_zero: assert property (hrdata[31:8] == 24'h0) else $error("hrdata upper bits not zero");
    a_wo_zero:
        assert property (take && !hwrite && low_addr && (idx == IDX_SOFT_RESET || idx == IDX_IRQ_CTRL)
            |=> hrdata == 32'h0) else $error("write-only register read nonzero");
    a_unmapped_zero: assert property (take && !hwrite && !low_addr |=> hrdata == 32'h0)
        else $error("unmapped read nonzero");
    a_rdata_hold: assert property (!(take && !hwrite) |=> $stable(hrdata)) else $error("hrdata changed without read");
    a_cfg_clear:
        assert property (take && hwrite && low_addr && (idx == IDX_MODE_AXIS || idx == IDX_WM_LEVEL)
            ##1 !sample_valid |-> ##2 (!irq_pin_a && !irq_pin_b)) else $error("irq pin high after config write");
endmodule

// ===== sample_src.sv
// sample source model: emits one frame pulse per request
`timescale 1ns/1ps
module sample_src
    import accel_buf_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic         fire,
    input  wire accel_frame_t frame_in,
    output logic              sample_valid,
    output accel_frame_t      sample
);
    always_ff @(posedge clk) begin
        sample_valid <= nrst && fire;
        // whole frame from one instant, scrambled outside the pulse
        if (!nrst) begin
            sample <= '0;
        end else begin
            sample <= fire ? frame_in : ~sample;
        end
    end
endmodule

// ===== accel_sample_fifo_test.sv
// self-checking bench for the acceleration frame buffer
`timescale 1ns/1ps
module accel_sample_fifo_test
    import accel_buf_pkg::*;
;
    logic         clk = 1'b0;
    logic         nrst = 1'b0;
    logic         hsel = 1'b0;
    logic         hwrite = 1'b0;
    logic         fire = 1'b0;
    logic [1:0]   htrans = 2'h0;
    logic [2:0]   hsize = 3'h2;
    logic [31:0]  haddr = 32'h0;
    logic [31:0]  hwdata = 32'h0;
    logic [31:0]  hrdata;
    logic         hreadyout, hresp, sample_valid, irq_pin_a, irq_pin_b;
    accel_frame_t sample;
    accel_frame_t frame_in = '0;
    logic [7:0]   rv;
    int           err_total = 0;
    int           n_checks = 0;
    int           seed = 38435;
    accel_frame_t q[$];

    always #2.5 clk = ~clk;

    sample_src src (.clk(clk), .nrst(nrst), .fire(fire), .frame_in(frame_in), .sample_valid(sample_valid),
                    .sample(sample));
    accel_sample_fifo uut (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
                           .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
                           .hrdata(hrdata), .hresp(hresp), .sample_valid(sample_valid), .sample(sample),
                           .irq_pin_a(irq_pin_a), .irq_pin_b(irq_pin_b));

    task automatic results;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic cmp(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic wait_rdy;
        int n;
        n = 0;
        @(posedge clk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 20) begin
                err_total++;
                results();
            end
            @(posedge clk);
        end
    endtask

    task automatic bus(input logic w, input logic [31:0] a, input logic [7:0] d);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= w;
        htrans <= 2'h2;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        wait_rdy();
        rv = hrdata[7:0];
    endtask

    // idle cycle after a write avoids reading pre-write state
    task automatic wr(input logic [5:0] i, input logic [7:0] d);
        bus(1'b1, {24'h0, i, 2'h0}, d);
        @(posedge clk);
    endtask

    task automatic chk(input logic [5:0] i, input logic [7:0] e);
        bus(1'b0, {24'h0, i, 2'h0}, 8'h00);
        cmp(rv, e);
    endtask

    task automatic push(input accel_frame_t f);
        fire     <= 1'b1;
        frame_in <= f;
        @(posedge clk);
        fire <= 1'b0;
        @(posedge clk);
    endtask

    function automatic logic [7:0] fbyte(input accel_frame_t f, input int a, input int hi);
        logic [15:0] v;
        v = (a == 0) ? f.x : (a == 1) ? f.y : f.z;
        return hi ? v[15:8] : v[7:0];
    endfunction

    initial begin
        logic [63:0]  r;
        accel_frame_t f, last;
        logic [1:0]   md, ax;
        logic         ov, wm, fl, en;
        int           nf, cap, cn;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        chk(IDX_MODE_AXIS, 8'h00);
        wr(IDX_IRQ_CTRL, 8'h80);
        chk(IDX_IRQ_CTRL, 8'h00);
        chk(IDX_SOFT_RESET, 8'h00);
        chk(6'h3D, 8'h00);
        bus(1'b0, 32'h0000_0100, 8'h00);
        cmp(rv, 8'h00);
        for (int k = 0; k < 4; k++) begin
            md = (k == 1) ? MODE_STREAM : (k == 2) ? MODE_BYPASS : MODE_KEEP_FIRST;
            ax = 2'(k);
            nf = (k == 2) ? 3 : 33 + k;
            cap = (md == MODE_KEEP_FIRST) ? 32 : (md == MODE_STREAM) ? 31 : 1;
            en = (k != 3);
            wr(IDX_MODE_AXIS, {md, 4'h0, ax});
            chk(IDX_MODE_AXIS, {md, 4'h0, ax});
            chk(IDX_FRAME_COUNT, 8'h00);
            wr(IDX_IRQ_ENABLE, en ? 8'h60 : 8'h00);
            wr(IDX_IRQ_MAP, k[0] ? 8'h44 : 8'h22);
            wr(IDX_WM_LEVEL, 8'h02);
            q.delete();
            for (int j = 0; j < nf; j++) begin
                r = {$random(seed), $random(seed)};
                f = (j == 0) ? 48'h8000_7FFF_00FF : r[47:0];
                push(f);
                if (q.size() < cap || md != MODE_KEEP_FIRST) q.push_back(f);
                if (q.size() > cap) void'(q.pop_front());
                last = f;
            end
            repeat (3) @(posedge clk);
            cn = q.size();
            ov = (nf > cap);
            wm = en && cn >= 2;
            fl = en && cn >= cap;
            chk(IDX_FRAME_COUNT, {ov, 1'b0, 6'(cn)});
            wr(IDX_FRAME_COUNT, 8'h00);
            chk(IDX_FRAME_COUNT, {ov, 1'b0, 6'(cn)});
            for (int i = 0; i < 6; i++) chk(IDX_X_LO + 6'(i), fbyte(last, i / 2, i % 2));
            chk(IDX_IRQ_STATUS, {1'b0, wm, fl, 5'h0});
            cmp({6'h0, irq_pin_b, irq_pin_a}, k[0] ? {6'h0, wm, fl} : {6'h0, fl, wm});
            if (k == 0) begin
                chk(IDX_READOUT, fbyte(q[0], 0, 0));
                repeat (310) @(posedge clk);
                void'(q.pop_front());
                chk(IDX_FRAME_COUNT, {ov, 1'b0, 6'(cn - 1)});
            end
            while (q.size() > 0) begin
                f = q.pop_front();
                for (int a = 0; a < 3; a++) begin
                    if (ax == 2'h0 || int'(ax) == a + 1) begin
                        chk(IDX_READOUT, fbyte(f, a, 0));
                        chk(IDX_READOUT, fbyte(f, a, 1));
                    end
                end
            end
            chk(IDX_READOUT, 8'h00);
            chk(IDX_FRAME_COUNT, {ov, 7'h0});
            chk(IDX_IRQ_STATUS, 8'h00);
            cmp({6'h0, irq_pin_b, irq_pin_a}, 8'h00);
        end
        // reserved mode code acts as bypass, then a config write on a full buffer
        wr(IDX_MODE_AXIS, 8'hC0);
        chk(IDX_MODE_AXIS, 8'hC0);
        wr(IDX_IRQ_ENABLE, 8'h60);
        wr(IDX_IRQ_MAP, 8'h22);
        wr(IDX_WM_LEVEL, 8'h01);
        for (int j = 0; j < 2; j++) begin
            r = {$random(seed), $random(seed)};
            push(r[47:0]);
        end
        repeat (3) @(posedge clk);
        chk(IDX_FRAME_COUNT, 8'h81);
        chk(IDX_IRQ_STATUS, 8'h60);
        cmp({6'h0, irq_pin_b, irq_pin_a}, 8'h03);
        wr(IDX_WM_LEVEL, 8'h01);
        chk(IDX_FRAME_COUNT, 8'h00);
        chk(IDX_IRQ_STATUS, 8'h00);
        cmp({6'h0, irq_pin_b, irq_pin_a}, 8'h00);
        wr(IDX_SOFT_RESET, 8'hB6);
        chk(IDX_SOFT_RESET, 8'h00);
        chk(IDX_MODE_AXIS, 8'h00);
        chk(IDX_IRQ_ENABLE, 8'h00);
        results();
    end
endmodule

bind accel_sample_fifo accel_sample_fifo_sva chk_sva (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .sample_valid(sample_valid), .irq_pin_a(irq_pin_a), .irq_pin_b(irq_pin_b));
